// *** src/pwr_cal_ctrl.sv ***
module pwr_cal_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic hardware_reset_pin_n,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_mode,
    input wire logic ctrl_wr,
    input wire logic [1:0] power_down_select,
    input wire logic [1:0] calibration_select,
    input wire logic [1:0] sequencer_mode,
    input wire logic [2:0] input_channel_select,
    input wire logic coef_wr,
    input wire pwr_cal_pkg::coef_s coef_wdata,
    input wire logic [pwr_cal_pkg::coef_w-1:0] cal_result,
    input wire logic coefficient_readback_select,
    input wire pwr_cal_pkg::bypass_s bypass_in,
    input wire logic [1:0] pin_enable,
    input wire logic [1:0] pin_dir_out,
    input wire logic [1:0] pin_output_value,
    input wire logic [1:0] pin_in,
    output pwr_cal_pkg::coef_s coef_rdata,
    output pwr_cal_pkg::coef_s coef_applied,
    output pwr_cal_pkg::bypass_s bypass_q,
    output logic [1:0] power_state_status,
    output logic reset_in_progress_flag,
    output logic regs_default,
    output logic cal_short_inputs,
    output logic cal_ref_inputs,
    output logic [2:0] cal_channel,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    output logic [1:0] pin_value_q
);
    localparam int cw = pwr_cal_pkg::cnt_w;

    pwr_cal_pkg::pstate_e state_q, state_d;
    logic [cw-1:0] cnt_q, cnt_d;
    logic [1:0] target_q, target_d;
    logic [1:0] cal_kind_q;
    logic cal_phase_q;
    logic [1:0] hw_sync_q, pin_s1_q, pin_s2_q;
    pwr_cal_pkg::coef_s host_q, int_q;

    // reset pin passes two flops; first stage read only by second
    wire hw_rst_n = hw_sync_q[1];
    wire cnt_done = (cnt_q == '0);
    wire power_cmd = cmd_valid && (cmd_mode == pwr_cal_pkg::mode_power);
    wire conv_cmd = cmd_valid && (cmd_mode == pwr_cal_pkg::mode_convert);
    wire cal_ok = (sequencer_mode == pwr_cal_pkg::seq_mode1);
    wire cal_cmd = cmd_valid && (cmd_mode == pwr_cal_pkg::mode_cal) && cal_ok;
    wire is_sleep_cmd = power_cmd && (power_down_select == pwr_cal_pkg::pd_sleep);
    wire is_sby_cmd = power_cmd && (power_down_select == pwr_cal_pkg::pd_standby);
    wire is_rst_cmd = power_cmd && (power_down_select == pwr_cal_pkg::pd_reset);
    wire busy = (state_q == pwr_cal_pkg::st_active) || (state_q == pwr_cal_pkg::st_cal);
    wire conv_start = conv_cmd && ((state_q == pwr_cal_pkg::st_standby) || (state_q == pwr_cal_pkg::st_sleep));
    wire [cw-1:0] self_cal_len = cw'(pwr_cal_pkg::self_cal_cyc);
    wire [cw-1:0] sys_cal_len = cw'(pwr_cal_pkg::sys_cal_cyc);

    always_comb begin
        state_d = state_q;
        target_d = target_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - cw'(1);
        unique case (state_q)
            pwr_cal_pkg::st_off: begin
                if (cnt_done) begin
                    state_d = pwr_cal_pkg::st_standby;
                end
            end
            pwr_cal_pkg::st_standby: begin
                if (is_sleep_cmd) begin
                    state_d = pwr_cal_pkg::st_wake;
                    target_d = pwr_cal_pkg::stat_sleep;
                    cnt_d = cw'(pwr_cal_pkg::slp_from_sby_cyc);
                end else if (is_rst_cmd) begin
                    state_d = pwr_cal_pkg::st_reset;
                    cnt_d = cw'(pwr_cal_pkg::rst_sby_cyc);
                end else if (conv_cmd) begin
                    state_d = pwr_cal_pkg::st_active;
                end else if (cal_cmd) begin
                    state_d = pwr_cal_pkg::st_cal;
                    cnt_d = (calibration_select == pwr_cal_pkg::cal_self) ? self_cal_len : sys_cal_len;
                end
            end
            pwr_cal_pkg::st_sleep: begin
                // reset command ignored while sleeping
                if (is_sby_cmd) begin
                    state_d = pwr_cal_pkg::st_wake;
                    target_d = pwr_cal_pkg::stat_standby;
                    cnt_d = cw'(pwr_cal_pkg::sby_from_slp_cyc);
                end else if (conv_cmd) begin
                    state_d = pwr_cal_pkg::st_active;
                end
            end
            pwr_cal_pkg::st_active, pwr_cal_pkg::st_cal: begin
                if (is_rst_cmd) begin
                    state_d = pwr_cal_pkg::st_reset;
                    cnt_d = cw'(pwr_cal_pkg::rst_act_cyc);
                end else if (is_sleep_cmd) begin
                    // fast path: one short step from active
                    state_d = pwr_cal_pkg::st_wake;
                    target_d = pwr_cal_pkg::stat_sleep;
                    cnt_d = cw'(pwr_cal_pkg::slp_act_cyc);
                end else if (is_sby_cmd) begin
                    state_d = pwr_cal_pkg::st_wake;
                    target_d = pwr_cal_pkg::stat_standby;
                    cnt_d = cw'(pwr_cal_pkg::sby_act_cyc);
                end else if (ctrl_wr && state_q == pwr_cal_pkg::st_active) begin
                    state_d = pwr_cal_pkg::st_standby;
                end else if (state_q == pwr_cal_pkg::st_cal && cnt_done) begin
                    state_d = pwr_cal_pkg::st_standby;
                end
            end
            pwr_cal_pkg::st_reset, pwr_cal_pkg::st_wake: begin
                if (cnt_done) begin
                    state_d = (state_q == pwr_cal_pkg::st_reset || target_q == pwr_cal_pkg::stat_standby)
                        ? pwr_cal_pkg::st_standby : pwr_cal_pkg::st_sleep;
                end
            end
        endcase
        if (!hw_rst_n) begin
            state_d = pwr_cal_pkg::st_reset;
            cnt_d = cw'(pwr_cal_pkg::hwrst_settle_cyc);
        end
    end

    // status moves only once the state has settled
    wire [1:0] status_d =
        (state_d == pwr_cal_pkg::st_standby) ? pwr_cal_pkg::stat_standby :
        (state_d == pwr_cal_pkg::st_sleep) ? pwr_cal_pkg::stat_sleep :
        (state_d == pwr_cal_pkg::st_active || state_d == pwr_cal_pkg::st_cal) ? pwr_cal_pkg::stat_active :
        (state_d == pwr_cal_pkg::st_reset || state_d == pwr_cal_pkg::st_off) ? pwr_cal_pkg::stat_reset :
        power_state_status;
    wire do_defaults = (state_q == pwr_cal_pkg::st_reset);
    wire [cw-1:0] cal_half = (cal_kind_q == pwr_cal_pkg::cal_self) ? (self_cal_len >> 1) : '0;
    wire cal_end_phase = (state_q == pwr_cal_pkg::st_cal) && (cnt_q == cal_half) && !cnt_done;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= pwr_cal_pkg::st_off;
            cnt_q <= cw'(pwr_cal_pkg::por_settle_cyc);
            target_q <= pwr_cal_pkg::stat_standby;
            hw_sync_q <= 2'h3;
            power_state_status <= pwr_cal_pkg::stat_reset;
            reset_in_progress_flag <= 1'h1;
            regs_default <= 1'h1;
        end else if (clk_en) begin
            hw_sync_q <= {hw_sync_q[0], hardware_reset_pin_n};
            state_q <= state_d;
            cnt_q <= cnt_d;
            target_q <= target_d;
            power_state_status <= status_d;
            reset_in_progress_flag <= (state_d == pwr_cal_pkg::st_reset) || (state_d == pwr_cal_pkg::st_off);
            regs_default <= do_defaults;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_q <= {pwr_cal_pkg::offset_rst, pwr_cal_pkg::gain_rst, pwr_cal_pkg::offset_rst, pwr_cal_pkg::gain_rst};
            int_q <= {pwr_cal_pkg::offset_rst, pwr_cal_pkg::gain_rst, pwr_cal_pkg::offset_rst, pwr_cal_pkg::gain_rst};
            cal_kind_q <= pwr_cal_pkg::cal_self;
            cal_phase_q <= 1'h0;
            cal_channel <= pwr_cal_pkg::chan_rst;
        end else if (clk_en) begin
            if (do_defaults) begin
                host_q <= {pwr_cal_pkg::offset_rst, pwr_cal_pkg::gain_rst, pwr_cal_pkg::offset_rst, pwr_cal_pkg::gain_rst};
                int_q <= {pwr_cal_pkg::offset_rst, pwr_cal_pkg::gain_rst, pwr_cal_pkg::offset_rst, pwr_cal_pkg::gain_rst};
            end else if (coef_wr) begin
                host_q <= coef_wdata;
            end else if (conv_start) begin
                int_q <= host_q;
            end else if (cal_end_phase) begin
                // calibration leaves the host copy alone
                if (cal_kind_q == pwr_cal_pkg::cal_self && !cal_phase_q)
                    int_q.self_offset_coefficient <= cal_result;
                else if (cal_kind_q == pwr_cal_pkg::cal_self)
                    int_q.self_gain_coefficient <= cal_result;
                else if (cal_kind_q == pwr_cal_pkg::cal_sys_off)
                    int_q.system_offset_coefficient <= cal_result;
                else
                    int_q.system_gain_coefficient <= cal_result;
            end
            if (cal_cmd && state_q == pwr_cal_pkg::st_standby) begin
                cal_kind_q <= calibration_select;
                cal_phase_q <= 1'h0;
                cal_channel <= input_channel_select;
            end else if (cal_end_phase) begin
                cal_phase_q <= 1'h1;
            end
        end
    end

    wire in_self = (state_q == pwr_cal_pkg::st_cal) && (cal_kind_q == pwr_cal_pkg::cal_self);
    pwr_cal_pkg::coef_s bypassed;
    assign bypassed.self_offset_coefficient = bypass_in.self_offset_bypass ? pwr_cal_pkg::offset_rst
        : int_q.self_offset_coefficient;
    assign bypassed.self_gain_coefficient = bypass_in.self_gain_bypass ? pwr_cal_pkg::gain_rst
        : int_q.self_gain_coefficient;
    assign bypassed.system_offset_coefficient = bypass_in.system_offset_bypass ? pwr_cal_pkg::offset_rst
        : int_q.system_offset_coefficient;
    assign bypassed.system_gain_coefficient = bypass_in.system_gain_bypass ? pwr_cal_pkg::gain_rst
        : int_q.system_gain_coefficient;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coef_rdata <= '0;
            coef_applied <= '0;
            bypass_q <= '0;
            cal_short_inputs <= 1'h0;
            cal_ref_inputs <= 1'h0;
        end else if (clk_en) begin
            coef_rdata <= coefficient_readback_select ? int_q : host_q;
            coef_applied <= bypassed;
            bypass_q <= bypass_in;
            cal_short_inputs <= in_self && !cal_phase_q;
            cal_ref_inputs <= in_self && cal_phase_q;
        end
    end

    // pins: input by default, output only when enabled and set as output
    for (genvar i = 0; i < 2; i++) begin : g_pin
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                pin_oe[i] <= 1'h0;
                pin_out[i] <= 1'h0;
                pin_s1_q[i] <= 1'h0;
                pin_s2_q[i] <= 1'h0;
                pin_value_q[i] <= 1'h0;
            end else if (clk_en) begin
                pin_oe[i] <= pin_enable[i] && pin_dir_out[i] && !do_defaults;
                pin_out[i] <= pin_output_value[i];
                pin_s1_q[i] <= pin_in[i];
                pin_s2_q[i] <= pin_s1_q[i];
                pin_value_q[i] <= pin_enable[i] ? pin_s2_q[i] : 1'h0;
            end
        end
    end

    property p_reset_flag;
        @(posedge clk) disable iff (rst)
        reset_in_progress_flag |-> power_state_status == pwr_cal_pkg::stat_reset;
    endproperty
    a_reset_flag: assert property (p_reset_flag) else $error("flag without reset status");

    property p_abort;
        @(posedge clk) disable iff (rst)
        (clk_en && hw_rst_n && state_q == pwr_cal_pkg::st_active && ctrl_wr && !power_cmd)
        |=> state_q == pwr_cal_pkg::st_standby;
    endproperty
    a_abort: assert property (p_abort) else $error("control write did not abort");

    property p_rst_act;
        @(posedge clk) disable iff (rst)
        (clk_en && hw_rst_n && busy && is_rst_cmd)
        |=> state_q == pwr_cal_pkg::st_reset && cnt_q == cw'(pwr_cal_pkg::rst_act_cyc);
    endproperty
    a_rst_act: assert property (p_rst_act) else $error("reset from active wrong");

    property p_sleep_ign;
        @(posedge clk) disable iff (rst)
        (clk_en && hw_rst_n && state_q == pwr_cal_pkg::st_sleep && is_rst_cmd) |=> state_q == pwr_cal_pkg::st_sleep;
    endproperty
    a_sleep_ign: assert property (p_sleep_ign) else $error("reset in sleep not ignored");

    property p_cal_gate;
        @(posedge clk) disable iff (rst)
        (clk_en && hw_rst_n && state_q == pwr_cal_pkg::st_standby && cmd_valid && cmd_mode == pwr_cal_pkg::mode_cal
            && !cal_ok) |=> state_q == pwr_cal_pkg::st_standby;
    endproperty
    a_cal_gate: assert property (p_cal_gate) else $error("calibration outside mode 00");

    property p_copy;
        @(posedge clk) disable iff (rst)
        (clk_en && conv_start && !do_defaults && !coef_wr) |=> int_q == $past(host_q);
    endproperty
    a_copy: assert property (p_copy) else $error("coefficients not copied");

    property p_pin_in;
        @(posedge clk) disable iff (rst)
        (clk_en && !pin_dir_out[0]) |=> !pin_oe[0];
    endproperty
    a_pin_in: assert property (p_pin_in) else $error("input pin driven");

    property p_sby_wake;
        @(posedge clk) disable iff (rst)
        (clk_en && hw_rst_n && state_q == pwr_cal_pkg::st_sleep && is_sby_cmd)
        |=> state_q == pwr_cal_pkg::st_wake && cnt_q == cw'(pwr_cal_pkg::sby_from_slp_cyc);
    endproperty
    a_sby_wake: assert property (p_sby_wake) else $error("standby wake count wrong");

    property p_conv_start;
        @(posedge clk) disable iff (rst)
        (clk_en && hw_rst_n && conv_start) |=> power_state_status == pwr_cal_pkg::stat_active;
    endproperty
    a_conv_start: assert property (p_conv_start) else $error("convert did not go active");

    property p_wake_hold;
        @(posedge clk) disable iff (rst)
        (clk_en && hw_rst_n && state_q == pwr_cal_pkg::st_wake && !cnt_done) |=> $stable(power_state_status);
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("status moved before transition ended");

    property p_reset_done;
        @(posedge clk) disable iff (rst)
        (clk_en && hw_rst_n && state_q == pwr_cal_pkg::st_reset && cnt_done)
        |=> power_state_status == pwr_cal_pkg::stat_standby && !reset_in_progress_flag;
    endproperty
    a_reset_done: assert property (p_reset_done) else $error("reset end not reported");

    property p_defaults;
        @(posedge clk) disable iff (rst)
        (clk_en && do_defaults) |=> host_q.self_gain_coefficient == pwr_cal_pkg::gain_rst
            && int_q.system_offset_coefficient == pwr_cal_pkg::offset_rst;
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults not restored");

    property p_cal_host;
        @(posedge clk) disable iff (rst)
        (clk_en && cal_end_phase && !coef_wr) |=> host_q == $past(host_q);
    endproperty
    a_cal_host: assert property (p_cal_host) else $error("calibration touched host copy");

    property p_cal_offset;
        @(posedge clk) disable iff (rst)
        (clk_en && cal_end_phase && !cal_phase_q && cal_kind_q == pwr_cal_pkg::cal_self && !coef_wr)
        |=> int_q.self_offset_coefficient == $past(cal_result);
    endproperty
    a_cal_offset: assert property (p_cal_offset) else $error("offset phase result not stored");

    c_conv: cover property (@(posedge clk) disable iff (rst) state_q == pwr_cal_pkg::st_active);
    c_cal: cover property (@(posedge clk) disable iff (rst) cal_end_phase);
    c_sleep: cover property (@(posedge clk) disable iff (rst) state_q == pwr_cal_pkg::st_sleep);
    c_reset: cover property (@(posedge clk) disable iff (rst) state_q == pwr_cal_pkg::st_reset);
endmodule

// *** src/pwr_cal_pkg.sv ***
package pwr_cal_pkg;
    localparam int unsigned clk_hz = 20_000_000;
    localparam int unsigned coef_w = 24;
    // maximum delays and the calibration rate, in their own units
    localparam int unsigned sby_from_slp_ms = 20;
    localparam int unsigned slp_from_sby_ms = 20;
    localparam int unsigned fast_exit_us = 85;
    localparam int unsigned rst_sby_ms = 28;
    localparam int unsigned rst_act_us = 6;
    localparam int unsigned slp_act_us = 3;
    localparam int unsigned sby_act_us = 3;
    localparam int unsigned por_ms = 10;
    localparam int unsigned hwrst_ms = 10;
    localparam int unsigned self_cal_ms = 200;
    localparam int unsigned sys_cal_ms = 100;
    localparam int unsigned cal_rate_sps = 50;
    // longest times round down
    localparam int unsigned sby_from_slp_cyc = sby_from_slp_ms * (clk_hz / 1000);
    localparam int unsigned slp_from_sby_cyc = slp_from_sby_ms * (clk_hz / 1000);
    localparam int unsigned fast_exit_cyc = fast_exit_us * (clk_hz / 1_000_000);
    localparam int unsigned rst_sby_cyc = rst_sby_ms * (clk_hz / 1000);
    localparam int unsigned rst_act_cyc = rst_act_us * (clk_hz / 1_000_000);
    localparam int unsigned slp_act_cyc = slp_act_us * (clk_hz / 1_000_000);
    localparam int unsigned sby_act_cyc = sby_act_us * (clk_hz / 1_000_000);
    localparam int unsigned por_cyc = por_ms * (clk_hz / 1000);
    localparam int unsigned hwrst_cyc = hwrst_ms * (clk_hz / 1000);
    localparam int unsigned self_cal_cyc = self_cal_ms * (clk_hz / 1000);
    localparam int unsigned sys_cal_cyc = sys_cal_ms * (clk_hz / 1000);
    localparam int unsigned cal_phase_cyc = clk_hz / cal_rate_sps;
    // settle times the sequencer really takes, well inside the limits above
    localparam int unsigned por_settle_cyc = 2000;
    localparam int unsigned hwrst_settle_cyc = 2000;
    // field encodings
    localparam logic [1:0] pd_sleep = 2'h1;
    localparam logic [1:0] pd_standby = 2'h2;
    localparam logic [1:0] pd_reset = 2'h3;
    localparam logic [1:0] mode_power = 2'h1;
    localparam logic [1:0] mode_cal = 2'h2;
    localparam logic [1:0] mode_convert = 2'h3;
    localparam logic [1:0] seq_mode1 = 2'h0;
    localparam logic [1:0] cal_self = 2'h0;
    localparam logic [1:0] cal_sys_off = 2'h1;
    localparam logic [1:0] cal_sys_gain = 2'h2;
    localparam logic [1:0] stat_active = 2'h0;
    localparam logic [1:0] stat_sleep = 2'h1;
    localparam logic [1:0] stat_standby = 2'h2;
    localparam logic [1:0] stat_reset = 2'h3;
    localparam logic [23:0] offset_rst = 24'h000000;
    localparam logic [23:0] gain_rst = 24'h800000;
    localparam logic [2:0] chan_rst = 3'h0;
    localparam int unsigned cnt_w = 23;

    typedef struct packed {
        logic [coef_w-1:0] self_offset_coefficient;
        logic [coef_w-1:0] self_gain_coefficient;
        logic [coef_w-1:0] system_offset_coefficient;
        logic [coef_w-1:0] system_gain_coefficient;
    } coef_s;

    typedef struct packed {
        logic self_offset_bypass;
        logic self_gain_bypass;
        logic system_offset_bypass;
        logic system_gain_bypass;
    } bypass_s;

    typedef enum logic [6:0] {
        st_off = 7'h01,
        st_standby = 7'h02,
        st_sleep = 7'h04,
        st_active = 7'h08,
        st_cal = 7'h10,
        st_reset = 7'h20,
        st_wake = 7'h40
    } pstate_e;
endpackage

// *** tb/host_model.sv ***
module host_model (
    input wire logic clk,
    input wire logic [1:0] power_state_status,
    output logic cmd_valid,
    output logic [1:0] cmd_mode,
    output logic ctrl_wr,
    output logic [1:0] power_down_select,
    output logic [1:0] calibration_select,
    output logic [1:0] sequencer_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cmd_valid = 1'b0;
        cmd_mode = 2'h0;
        ctrl_wr = 1'b0;
        power_down_select = 2'h2;
        calibration_select = 2'h0;
        sequencer_mode = 2'h0;
    end
    // field first, then the command a cycle later
    task automatic issue(input logic [1:0] pd, input logic [1:0] seq, input logic [1:0] mode);
        @(posedge clk);
        #2 power_down_select = pd;
        sequencer_mode = seq;
        @(posedge clk);
        #2 cmd_valid = 1'b1;
        cmd_mode = mode;
        @(posedge clk);
        #2 cmd_valid = 1'b0;
    endtask
    task automatic wr_ctrl();
        @(posedge clk);
        #2 ctrl_wr = 1'b1;
        @(posedge clk);
        #2 ctrl_wr = 1'b0;
    endtask
    // no command queue: the next request waits for the target status
    task automatic poll(input logic [1:0] want, input int bound, output bit ok);
        ok = 1'b0;
        for (int i = 0; i < bound && !ok; i++) begin
            @(posedge clk);
            #2 ok = (power_state_status === want);
        end
    endtask
endmodule

// *** tb/test_pwr_cal_ctrl.sv ***
module test_pwr_cal_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hw_rst_n = 1'b1;
    logic cmd_valid, ctrl_wr, coef_wr = 1'b0, rb_sel = 1'b0;
    logic [1:0] cmd_mode, pd, cal_sel, seq_mode;
    logic [1:0] pin_en = 2'h0, pin_dir = 2'h0, pin_val = 2'h0, pin_in = 2'h2;
    pwr_cal_pkg::coef_s wdata = '0, rdata, applied, exp_c;
    pwr_cal_pkg::bypass_s byp = '0, byp_q;
    logic [1:0] stat, pin_out, pin_oe, pin_vq;
    logic flag, regs_def, c_short, c_ref;
    logic [2:0] c_chan;
    logic [2:0] chan = 3'h5;
    int miscompares = 0;
    int cmp_count = 0;
    always #25 clk = ~clk;
    pwr_cal_ctrl dut (.clk(clk), .rst(rst), .clk_en(1'b1), .hardware_reset_pin_n(hw_rst_n),
        .cmd_valid(cmd_valid), .cmd_mode(cmd_mode), .ctrl_wr(ctrl_wr), .power_down_select(pd),
        .calibration_select(cal_sel), .sequencer_mode(seq_mode), .input_channel_select(chan),
        .coef_wr(coef_wr), .coef_wdata(wdata), .cal_result(24'h123456), .coefficient_readback_select(rb_sel),
        .bypass_in(byp), .pin_enable(pin_en), .pin_dir_out(pin_dir), .pin_output_value(pin_val),
        .pin_in(pin_in), .coef_rdata(rdata), .coef_applied(applied), .bypass_q(byp_q),
        .power_state_status(stat), .reset_in_progress_flag(flag), .regs_default(regs_def),
        .cal_short_inputs(c_short), .cal_ref_inputs(c_ref), .cal_channel(c_chan), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_value_q(pin_vq));
    host_model host (.clk(clk), .power_state_status(stat), .cmd_valid(cmd_valid), .cmd_mode(cmd_mode),
        .ctrl_wr(ctrl_wr), .power_down_select(pd), .calibration_select(cal_sel), .sequencer_mode(seq_mode));
    task automatic tally_and_finish();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // a bound that runs out ends the run as a failure
    task automatic wait_stat(input logic [1:0] want, input int bound);
        bit ok;
        host.poll(want, bound, ok);
        if (!ok) begin
            miscompares++;
            tally_and_finish();
        end
        check(96'(stat), 96'(want));
    endtask
    task automatic convert();
        host.issue(pwr_cal_pkg::pd_standby, pwr_cal_pkg::seq_mode1, pwr_cal_pkg::mode_convert);
        wait_stat(pwr_cal_pkg::stat_active, 4);
    endtask
    initial begin
        step(3);
        check({94'h0, flag, pin_oe[0]}, {94'h0, 2'b10});
        check(96'(stat), 96'(pwr_cal_pkg::stat_reset));
        rst = 1'b0;
        pin_en = 2'h3;
        pin_dir = 2'h1;
        pin_val = 2'h1;
        step(5);
        check({90'h0, pin_oe, pin_out[0], pin_vq[1], 2'h0}, {90'h0, 2'h1, 1'b1, 1'b1, 2'h0});
        pin_en = 2'h0;
        step(5);
        check(96'({pin_oe, pin_vq}), 96'h0);
        wait_stat(pwr_cal_pkg::stat_standby, pwr_cal_pkg::por_cyc + 100);
        check(96'(flag), 96'h0);
        step(50);
        check(96'(stat), 96'(pwr_cal_pkg::stat_standby));
        // calibration outside sequencer mode 00 must leave everything alone
        host.issue(pwr_cal_pkg::pd_standby, 2'h1, pwr_cal_pkg::mode_cal);
        step(5);
        check(96'(stat), 96'(pwr_cal_pkg::stat_standby));
        wdata = {24'h0a0b0c, 24'h7f0011, 24'h000123, 24'h812345};
        coef_wr = 1'b1;
        step(1);
        coef_wr = 1'b0;
        step(3);
        check(rdata, wdata);
        convert();
        step(3);
        check(applied, wdata);
        rb_sel = 1'b1;
        byp = 4'b1001;
        step(4);
        check(rdata, wdata);
        check(96'(byp_q), 96'(byp));
        exp_c = wdata;
        exp_c.self_offset_coefficient = pwr_cal_pkg::offset_rst;
        exp_c.system_gain_coefficient = pwr_cal_pkg::gain_rst;
        check(applied, exp_c);
        host.wr_ctrl();
        wait_stat(pwr_cal_pkg::stat_standby, 3);
        convert();
        host.issue(pwr_cal_pkg::pd_sleep, pwr_cal_pkg::seq_mode1, pwr_cal_pkg::mode_power);
        check(96'(stat), 96'(pwr_cal_pkg::stat_active));
        wait_stat(pwr_cal_pkg::stat_sleep, 70);
        host.issue(pwr_cal_pkg::pd_reset, pwr_cal_pkg::seq_mode1, pwr_cal_pkg::mode_power);
        step(10);
        check({94'h0, stat}, {94'h0, pwr_cal_pkg::stat_sleep});
        convert();
        host.issue(pwr_cal_pkg::pd_standby, pwr_cal_pkg::seq_mode1, pwr_cal_pkg::mode_power);
        wait_stat(pwr_cal_pkg::stat_standby, 70);
        convert();
        host.issue(pwr_cal_pkg::pd_reset, pwr_cal_pkg::seq_mode1, pwr_cal_pkg::mode_power);
        wait_stat(pwr_cal_pkg::stat_reset, 10);
        check(96'({flag, regs_def}), 96'h3);
        wait_stat(pwr_cal_pkg::stat_standby, 130);
        rb_sel = 1'b0;
        step(3);
        exp_c = {pwr_cal_pkg::offset_rst, pwr_cal_pkg::gain_rst, pwr_cal_pkg::offset_rst, pwr_cal_pkg::gain_rst};
        check(rdata, exp_c);
        check(96'(flag), 96'h0);
        // self calibration started, then cut short by a reset command
        host.issue(pwr_cal_pkg::pd_standby, pwr_cal_pkg::seq_mode1, pwr_cal_pkg::mode_cal);
        wait_stat(pwr_cal_pkg::stat_active, 4);
        step(2);
        check(96'({c_short, c_ref, c_chan}), 96'h15);
        host.issue(pwr_cal_pkg::pd_reset, pwr_cal_pkg::seq_mode1, pwr_cal_pkg::mode_power);
        wait_stat(pwr_cal_pkg::stat_standby, 130);
        check(96'({c_short, c_ref}), 96'h0);
        convert();
        hw_rst_n = 1'b0;
        step(5);
        hw_rst_n = 1'b1;
        wait_stat(pwr_cal_pkg::stat_reset, 10);
        wait_stat(pwr_cal_pkg::stat_standby, pwr_cal_pkg::hwrst_cyc + 100);
        tally_and_finish();
    end
endmodule
